// ### rtl/atcr_core.sv
/*
 * Acquisition start, sample counter trigger and scan clock sequencing,
 * with a software-set switch onto the shared eight-line trigger bus.
 * Assumes all local inputs are synchronous to clock; bus lines are not.
 */
`timescale 1ns/1ps
`include "atcr_regs.svh"

module atcr_core
    import atcr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // configuration
    input wire atcr_route_tab_t route,
    input wire logic pretrig_mode,
    input wire logic ext_clock_mode,
    // local triggers and clocks
    input wire atcr_loc_trig_t loc_trig,
    input wire logic int_scan_clock,
    input wire logic connector_scan_clock_n,
    input wire logic acq_done,
    // counter two
    input wire logic counter_two_q,
    output logic counter_two_gate,
    output logic counter_two_src,
    // acquisition outputs
    output logic acq_start,
    output logic counter_enable,
    output logic scan_start,
    output logic scan_clock_out,
    output logic acq_busy,
    // trigger bus, open drain style
    input wire logic [`ATCR_BUS_W-1:0] bus_in,
    output logic [`ATCR_BUS_W-1:0] bus_out,
    output logic [`ATCR_BUS_W-1:0] bus_oe_n
);

    // ***********************************
    // decode helpers
    // ***********************************

    // a signal listens on its line when connected and not driving
    function automatic logic rx(input atcr_route_t r);
        rx = r.en & ~r.drive;
    endfunction

    function automatic logic pick(input logic [`ATCR_BUS_W-1:0] v, input atcr_route_t r);
        pick = v[r.line];
    endfunction

    // ***********************************
    // bus input synchronisers
    // ***********************************
    logic [`ATCR_BUS_W-1:0] lvl, rise, fall;

    genvar g;
    generate
        for (g = 0; g < `ATCR_BUS_W; g++) begin : g_sync
            atcr_edge_sync u_sync (
                .clock(clock),
                .reset(reset),
                .din(bus_in[g]),
                .level(lvl[g]),
                .rise(rise[g]),
                .fall(fall[g])
            );
        end
    endgenerate

    // ***********************************
    // trigger sequencing
    // ***********************************
    atcr_state_t state_q, state_d;
    logic pend_q, pend_d;
    logic start_n_q, start_n_d;
    logic trig_n_q, trig_n_d;
    logic acq_start_q, acq_start_d;
    logic cnt_en_q, cnt_en_d, busy_q, busy_d;
    logic start_bus, trig_bus, loc_start, loc_hw, start_ev, trig_ev, idle, pre_st;
    // selection of start and trigger sources
    always_comb begin
        idle = (state_q == ATCR_IDLE);
        pre_st = (state_q == ATCR_PRE);
        loc_hw = loc_trig.analog | loc_trig.digital;
        start_bus = rx(route[`ATCR_SIG_START]);
        trig_bus = rx(route[`ATCR_SIG_TRIG]) & pretrig_mode;
        loc_start = loc_hw | (loc_trig.sw & pretrig_mode);
        start_ev = start_bus ? pick(fall, route[`ATCR_SIG_START]) : loc_start;
        if (!pretrig_mode) begin
            trig_ev = start_ev | (loc_trig.sw & ~start_bus);
        end else if (trig_bus) begin
            trig_ev = pre_st & pick(fall, route[`ATCR_SIG_TRIG]);
        end else begin
            trig_ev = pre_st & pend_q;
        end
    end

    // pending local hardware trigger waits until pretrigger phase is running
    always_comb begin
        pend_d = pend_q;
        if (pretrig_mode && !trig_bus && loc_hw) begin
            pend_d = 1'h1;
        end else if (trig_ev || !pretrig_mode || trig_bus) begin
            pend_d = 1'h0;
        end
        state_d = state_q;
        acq_start_d = 1'h0;
        cnt_en_d = 1'h0;
        case (state_q)
            ATCR_IDLE: begin
                if (pretrig_mode && start_ev) begin
                    state_d = ATCR_PRE;
                    acq_start_d = 1'h1;
                end else if (!pretrig_mode && trig_ev) begin
                    state_d = ATCR_POST;
                    acq_start_d = 1'h1;
                    cnt_en_d = 1'h1;
                end
            end
            ATCR_PRE: begin
                if (trig_ev) begin
                    state_d = ATCR_POST;
                    cnt_en_d = 1'h1;
                end
            end
            ATCR_POST: begin
                if (acq_done) begin
                    state_d = ATCR_IDLE;
                end
            end
            default: begin
                state_d = ATCR_IDLE;
            end
        endcase
        // local active-low pulses presented to the bus
        start_n_d = ~(loc_start & ~start_bus);
        trig_n_d = ~(pretrig_mode ? (pre_st & pend_q & ~trig_bus) : trig_ev);
        busy_d = (state_d != ATCR_IDLE);  // busy pin comes straight from a flop
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ATCR_IDLE;
            pend_q <= 1'h0;
            start_n_q <= `ATCR_RST_ACTIVE_N;
            trig_n_q <= `ATCR_RST_ACTIVE_N;
            acq_start_q <= 1'h0;
            cnt_en_q <= 1'h0;
            busy_q <= 1'h0;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            start_n_q <= start_n_d;
            trig_n_q <= trig_n_d;
            acq_start_q <= acq_start_d;
            cnt_en_q <= cnt_en_d;
            busy_q <= busy_d;
        end
    end

    // ***********************************
    // scan clock selection
    // ***********************************
    logic clko_q, clko_d;
    logic eff_prev_q, eff_prev_d;
    logic scan_q, scan_d;
    logic clki_bus, eff;

    // bus clock in, when routed, drives scan start whichever local clock software picked
    always_comb begin
        clko_d = ext_clock_mode ? ~connector_scan_clock_n : int_scan_clock;
        clki_bus = rx(route[`ATCR_SIG_CLKI]);
        eff = clki_bus ? pick(lvl, route[`ATCR_SIG_CLKI]) : clko_q;
        eff_prev_d = eff;
        scan_d = eff & ~eff_prev_q;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            clko_q <= 1'h0;
            eff_prev_q <= 1'h1;
            scan_q <= 1'h0;
        end else begin
            clko_q <= clko_d;
            eff_prev_q <= eff_prev_d;
            scan_q <= scan_d;
        end
    end

    // ***********************************
    // switch: bus drivers and receivers
    // ***********************************
    logic [`ATCR_BUS_W-1:0] bout_q, bout_d, boe_n_q, boe_n_d;
    logic gate_q, gate_d, src_q, src_d, counter_two_q_q, counter_two_q_d;
    logic [`ATCR_NUM_SIG-1:0] drv_sig, val_sig;

    // only codes 0, 1 (when set to drive), 2 and 6 may drive a line
    always_comb begin
        counter_two_q_d = counter_two_q;
        drv_sig = '0;
        drv_sig[`ATCR_SIG_START] = route[`ATCR_SIG_START].en & route[`ATCR_SIG_START].drive;
        drv_sig[`ATCR_SIG_TRIG] = route[`ATCR_SIG_TRIG].en & route[`ATCR_SIG_TRIG].drive;
        drv_sig[`ATCR_SIG_CLKO] = route[`ATCR_SIG_CLKO].en;
        drv_sig[`ATCR_SIG_COUNTER_TWO_Q] = route[`ATCR_SIG_COUNTER_TWO_Q].en;
        val_sig = '0;
        val_sig[`ATCR_SIG_START] = start_n_q;
        val_sig[`ATCR_SIG_TRIG] = trig_n_q;
        val_sig[`ATCR_SIG_CLKO] = clko_q;
        val_sig[`ATCR_SIG_COUNTER_TWO_Q] = counter_two_q_q;
        bout_d = {`ATCR_BUS_W{1'h1}};
        boe_n_d = `ATCR_RST_BUS_OE_N;
        // lower code wins when software wires two sources to one line
        for (int s = `ATCR_NUM_SIG - 1; s >= 0; s--) begin
            if (drv_sig[s]) begin
                bout_d[route[s].line] = val_sig[s];
                boe_n_d[route[s].line] = 1'h0;
            end
        end
        gate_d = rx(route[`ATCR_SIG_COUNTER_TWO_GATE]) & pick(lvl, route[`ATCR_SIG_COUNTER_TWO_GATE]);
        src_d = rx(route[`ATCR_SIG_SRC2]) & pick(lvl, route[`ATCR_SIG_SRC2]);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            bout_q <= {`ATCR_BUS_W{1'h1}};
            boe_n_q <= `ATCR_RST_BUS_OE_N;
            gate_q <= 1'h0;
            src_q <= 1'h0;
            counter_two_q_q <= 1'h0;
        end else begin
            bout_q <= bout_d;
            boe_n_q <= boe_n_d;
            gate_q <= gate_d;
            src_q <= src_d;
            counter_two_q_q <= counter_two_q_d;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign acq_start = acq_start_q;
    assign counter_enable = cnt_en_q;
    assign scan_start = scan_q;
    assign scan_clock_out = clko_q;
    assign acq_busy = busy_q;
    assign counter_two_gate = gate_q;
    assign counter_two_src = src_q;
    assign bus_out = bout_q;
    assign bus_oe_n = boe_n_q;

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    post_follow_a: assert property (acq_start && !$past(pretrig_mode) |-> counter_enable)
        else $error("posttrigger start without counter enable");
    pre_later_a: assert property ($past(pretrig_mode) && acq_start |-> !counter_enable)
        else $error("pretrigger trigger coincides with start");
    bus_start_a: assert property (idle && start_bus && pick(fall, route[0]) |=> acq_start)
        else $error("bus start pulse ignored");
    sw_start_a: assert property (pretrig_mode && idle && !start_bus && loc_trig.sw |=> acq_start)
        else $error("software start lost");
    bus_trig_a: assert property (trig_bus && pre_st && !pick(fall, route[1]) |=> !counter_enable)
        else $error("local trigger used while bus trigger routed");
    clk_bus_a: assert property (clki_bus && pick(lvl, route[3]) && !$past(pick(lvl, route[3])) ##1 clki_bus
        |-> scan_start)
        else $error("bus scan clock rise missed");
    clk_out_a: assert property (ext_clock_mode |=> scan_clock_out == !$past(connector_scan_clock_n))
        else $error("scan clock out not the connector clock");
    drive_map_a: assert property (boe_n_q[route[2].line] == 1'h0 || !$past(route[2].en)
        || $changed(route))
        else $error("routed scan clock out not driven");
    gate_route_a: assert property (rx(route[4]) ##1 $stable(route) |-> counter_two_gate ==
        $past(pick(lvl, route[4])))
        else $error("counter two gate not following its line");
    pre_seq_c: cover property (acq_start && pretrig_mode ##[1:20] counter_enable);
    post_seq_c: cover property (acq_start && counter_enable && !pretrig_mode);
    bus_clk_c: cover property (clki_bus && scan_start);

endmodule

// ### rtl/atcr_regs.svh
/*
 * Constants of the acquisition trigger and scan clock routing block:
 * signal codes of the routing switch, bus width and field widths.
 * Assumes it is included by the package and by the design modules.
 */
`ifndef ATCR_REGS_SVH
`define ATCR_REGS_SVH

// ***********************************
// routing switch geometry
// ***********************************
`define ATCR_NUM_SIG 7
`define ATCR_BUS_W 8
`define ATCR_LINE_W 3

// ***********************************
// signal codes of the switch
// ***********************************
`define ATCR_SIG_START 0
`define ATCR_SIG_TRIG 1
`define ATCR_SIG_CLKO 2
`define ATCR_SIG_CLKI 3
`define ATCR_SIG_COUNTER_TWO_GATE 4
`define ATCR_SIG_SRC2 5
`define ATCR_SIG_COUNTER_TWO_Q 6

// ***********************************
// reset values
// ***********************************
`define ATCR_RST_BUS_OE_N 8'hFF
`define ATCR_RST_ACTIVE_N 1'h1

`endif

// ### rtl/atcr_pkg.sv
/*
 * Types of the acquisition trigger and scan clock routing block.
 * Assumes atcr_regs.svh is on the include path.
 */
`include "atcr_regs.svh"

package atcr_pkg;

    // one switch entry: connected, drives the line (else receives), line
    typedef struct packed {
        logic en;
        logic drive;
        logic [`ATCR_LINE_W-1:0] line;
    } atcr_route_t;

    typedef atcr_route_t [`ATCR_NUM_SIG-1:0] atcr_route_tab_t;

    // one-cycle local trigger requests
    typedef struct packed {
        logic sw;
        logic analog;
        logic digital;
    } atcr_loc_trig_t;

    // acquisition sequence
    typedef enum logic [1:0] {
        ATCR_IDLE = 2'b00,
        ATCR_PRE = 2'b01,
        ATCR_POST = 2'b10
    } atcr_state_t;

endpackage

// ### rtl/atcr_edge_sync.sv
/*
 * Two-stage synchroniser with rise and fall detection for one bus line.
 * Assumes din is asynchronous to clock; outputs are in the clock domain.
 */
`timescale 1ns/1ps
`include "atcr_regs.svh"

module atcr_edge_sync
    import atcr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // line in
    input wire logic din,
    // synced level and edges
    output logic level,
    output logic rise,
    output logic fall
);

    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    // ***********************************
    // synchroniser
    // ***********************************

    // idle level of the bus is high, so reset to high avoids a false rise
    always_comb begin
        meta_d = din;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= 1'h1;
            sync_q <= 1'h1;
            prev_q <= 1'h1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // edges only look at the second stage and later
    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule

// ### sim/atcr_peer.sv
/*
 * peer board model: pulls trigger bus lines low, open-drain style.
 * assumes the bench resolves each line as a wired-and with a pull-up.
 */
`timescale 1ns/1ps
`include "atcr_regs.svh"

module atcr_peer (
    // clock
    input wire logic clock,
    // open-drain drive onto the trigger bus
    output logic [`ATCR_BUS_W-1:0] peer_out,
    output logic [`ATCR_BUS_W-1:0] peer_oe_n
);
    // released lines idle high through the pull-up, so nothing shows stale data
    initial begin
        peer_out = '1;
        peer_oe_n = '1;
    end

    // hold one line low for len cycles, then let it go; a release is a rise
    task automatic pulse_low(input logic [2:0] line, input int len);
        @(posedge clock);
        peer_out[line] <= 1'b0;
        peer_oe_n[line] <= 1'b0;
        repeat (len) @(posedge clock);
        peer_out[line] <= 1'b1;
        peer_oe_n[line] <= 1'b1;
    endtask
endmodule

// ### sim/testbench.sv
/*
 * testbench for the trigger and scan clock routing block with one peer.
 * assumes the rtl package and header are compiled first.
 */
`timescale 1ns/1ps
`include "atcr_regs.svh"

module testbench
    import atcr_pkg::*;
;
    logic clock, reset, pretrig_mode, ext_clock_mode, int_scan_clock, connector_scan_clock_n;
    logic acq_done, counter_two_q, counter_two_gate, counter_two_src;
    logic acq_start, counter_enable, scan_start, scan_clock_out, acq_busy;
    atcr_route_tab_t route;
    atcr_loc_trig_t loc_trig;
    logic [`ATCR_BUS_W-1:0] bus_out, bus_oe_n, peer_out, peer_oe_n, wire_lv;
    logic [7:0] low_seen;
    int err_count, tests_run, cyc;
    int cnt[3];
    int first[3];

    // ****************************************
    // design, peer and the wired-and bus
    // ****************************************
    assign wire_lv = (bus_out | bus_oe_n) & (peer_out | peer_oe_n);

    atcr_core u_dut (.clock, .reset, .route, .pretrig_mode, .ext_clock_mode, .loc_trig,
        .int_scan_clock, .connector_scan_clock_n, .acq_done, .counter_two_q, .counter_two_gate,
        .counter_two_src, .acq_start, .counter_enable, .scan_start, .scan_clock_out, .acq_busy,
        .bus_in(wire_lv), .bus_out, .bus_oe_n);

    atcr_peer u_peer (.clock, .peer_out, .peer_oe_n);

    // clock and a hang guard well above the run length
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            give_verdict();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic rt(input int code, input logic en, input logic drv, input logic [2:0] line);
        @(posedge clock);
        route[code] <= '{en, drv, line};
    endtask

    task automatic pulse(input atcr_loc_trig_t t);
        @(posedge clock);
        loc_trig <= t;
        @(posedge clock);
        loc_trig <= '0;
    endtask

    // count start, counter enable and scan pulses and note low bus lines
    task automatic watch(input int n);
        logic [2:0] v;
        cnt = '{0, 0, 0};
        first = '{-1, -1, -1};
        low_seen = 8'h00;
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            v = {scan_start, counter_enable, acq_start};
            low_seen = low_seen | ~wire_lv;
            for (int k = 0; k < 3; k++) begin
                if (v[k] === 1'b1) begin
                    if (first[k] < 0) first[k] = i;
                    cnt[k]++;
                end
            end
        end
    endtask

    task automatic finish_acq();
        @(posedge clock);
        acq_done <= 1'b1;
        @(posedge clock);
        acq_done <= 1'b0;
        repeat (2) @(negedge clock);
        check({7'h00, acq_busy}, 8'h00, "idle after done");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // every local source in both modes; start and trigger drive lines 2 and 3
    task automatic sc_local();
        int et;
        rt(0, 1'b1, 1'b1, 3'h2);
        rt(1, 1'b1, 1'b1, 3'h3);
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 3; s++) begin
                @(posedge clock);
                pretrig_mode <= m[0];
                et = (m == 1 && s == 0) ? 0 : 1;
                pulse(atcr_loc_trig_t'(3'h4 >> s));
                watch(6);
                check(8'(cnt[0]), 8'h01, "start count");
                check(8'(cnt[1]), 8'(et), "trigger count");
                check({7'h00, acq_busy}, 8'h01, "busy");
                check(low_seen, {4'h0, et == 1, (m == 1 || s != 0), 2'h0}, "lines pulsed");
                if (et == 1) begin
                    check({7'h00, first[1] > first[0]}, {7'h00, m[0]}, "trigger order");
                end else begin
                    pulse(3'h1);
                    watch(6);
                    check(8'(cnt[0] * 2 + cnt[1]), 8'h01, "later trigger only");
                end
                finish_acq();
            end
        end
    endtask

    // start taken from line 3; local software start must be discarded
    task automatic sc_bus_start();
        rt(0, 1'b1, 1'b0, 3'h3);
        rt(1, 1'b0, 1'b0, 3'h0);
        pretrig_mode <= 1'b0;
        pulse(3'h4);
        watch(6);
        check(8'(cnt[0]), 8'h00, "local start discarded");
        fork
            u_peer.pulse_low(3'h3, 2);
            watch(12);
        join
        check(8'(cnt[0]), 8'h01, "bus start");
        check(8'(cnt[1]), 8'h01, "post trigger follows start");
        finish_acq();
    endtask

    // pretrigger with trigger from line 4; local analog must not trigger
    task automatic sc_bus_trig();
        rt(0, 1'b1, 1'b1, 3'h2);
        rt(1, 1'b1, 1'b0, 3'h4);
        pretrig_mode <= 1'b1;
        pulse(3'h2);
        watch(6);
        check(8'(cnt[0] * 2 + cnt[1]), 8'h02, "start only");
        fork
            u_peer.pulse_low(3'h4, 2);
            watch(12);
        join
        check(8'(cnt[0] * 2 + cnt[1]), 8'h01, "bus trigger");
        finish_acq();
    endtask

    // local clock choice on scan_clock_out and line 5, then bus clock in on line 6
    task automatic sc_clock();
        rt(2, 1'b1, 1'b1, 3'h5);
        int_scan_clock <= 1'b1;
        watch(5);
        check({6'h00, scan_clock_out, wire_lv[5]}, 8'h03, "internal clock out");
        check(8'(cnt[2]), 8'h01, "internal scan");
        @(posedge clock);
        ext_clock_mode <= 1'b1;
        repeat (3) @(negedge clock);
        check({6'h00, scan_clock_out, wire_lv[5]}, 8'h00, "internal clock ignored");
        @(posedge clock);
        connector_scan_clock_n <= 1'b0;
        watch(5);
        check({6'h00, scan_clock_out, wire_lv[5]}, 8'h03, "connector clock out");
        check(8'(cnt[2]), 8'h01, "connector scan");
        rt(3, 1'b1, 1'b0, 3'h6);
        fork
            begin
                u_peer.pulse_low(3'h6, 3);
                repeat (3) @(posedge clock);
                u_peer.pulse_low(3'h6, 3);
            end
            repeat (8) begin
                @(posedge clock);
                int_scan_clock <= ~int_scan_clock;
                connector_scan_clock_n <= ~connector_scan_clock_n;
            end
            watch(24);
        join
        check(8'(cnt[2]), 8'h02, "bus clock only");
    endtask

    // counter two gate and source from line 7, output onto line 1
    task automatic sc_counter();
        rt(4, 1'b1, 1'b0, 3'h7);
        rt(5, 1'b1, 1'b0, 3'h7);
        rt(6, 1'b1, 1'b1, 3'h1);
        counter_two_q <= 1'b0;
        fork
            u_peer.pulse_low(3'h7, 6);
            begin
                repeat (5) @(negedge clock);
                check({6'h00, counter_two_gate, counter_two_src}, 8'h00, "gate src low");
                check({7'h00, wire_lv[1]}, 8'h00, "counter out low");
            end
        join
        counter_two_q <= 1'b1;
        repeat (5) @(negedge clock);
        check({6'h00, counter_two_gate, counter_two_src}, 8'h03, "gate src high");
        check({7'h00, wire_lv[1]}, 8'h01, "counter out high");
        check(bus_oe_n, 8'hD9, "only sources drive lines");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        route = '0;
        pretrig_mode = 1'b0;
        ext_clock_mode = 1'b0;
        loc_trig = '0;
        int_scan_clock = 1'b0;
        connector_scan_clock_n = 1'b1;
        acq_done = 1'b0;
        counter_two_q = 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(negedge clock);
        check(bus_oe_n, `ATCR_RST_BUS_OE_N, "oe after reset");
        check({5'h00, acq_busy, counter_two_gate, scan_clock_out}, 8'h00, "idle outputs");
        sc_local();
        sc_bus_start();
        sc_bus_trig();
        sc_clock();
        sc_counter();
        give_verdict();
    end
endmodule
